// >>> hdl/cia_accept.sv
`include "cia_defs.svh"
// Interrupt acceptance: sampling, priority, modes, acknowledge, vectoring
module cia_accept
  import cia_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Requests, active high levels (maskable line is wired-OR outside)
  input  wire logic        nmi_req_in,
  input  wire logic        int_req_in,
  // Instruction timing and bus
  input  wire logic        last_clock_in,
  input  wire logic        bus_granted_in,
  // Software control
  input  wire logic        enable_set_in,
  input  wire logic        enable_clr_in,
  input  wire logic        mode_wr_in,
  input  wire logic [1:0]  mode_code_in,
  input  wire logic [7:0]  vector_page_in,
  // Peripheral data bus and table load
  input  wire logic [7:0]  data_bus_in,
  input  wire logic        tbl_wr_in,
  input  wire logic [7:0]  tbl_addr_in,
  input  wire logic [7:0]  tbl_data_in,
  // Acknowledge strobes
  output logic             opcode_fetch_cycle_out,
  output logic             io_request_strobe_out,
  output logic             memory_request_strobe_out,
  output logic             wait_out,
  // Jump result
  output logic             jump_valid_out,
  output logic [15:0]      jump_addr_out,
  output logic             jump_is_instr_out,
  output logic [7:0]       jump_instr_out,
  // Status
  output logic             mode_select_high_out,
  output logic             mode_select_low_out,
  output logic             int_enabled_out
);
  cia_state_e state, next_state;
  logic       mode_select_high, next_mode_select_high;
  logic       mode_select_low, next_mode_select_low;
  logic       int_enabled, next_int_enabled;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic [7:0] vec, next_vec;
  logic [7:0] tbl_lo, next_tbl_lo;
  cia_ack_s   ack, next_ack;
  cia_jump_s  jump, next_jump;
  cia_kind_e  kind;
  logic [7:0] tbl_rd_addr;
  logic [7:0] tbl_rd_data;

  cia_table_mem #(.DEPTH(256)) i_cia_table_mem (
    .clk_in      (clk_in),
    .wr_en_in    (tbl_wr_in),
    .wr_addr_in  (tbl_addr_in),
    .wr_data_in  (tbl_data_in),
    .rd_addr_in  (tbl_rd_addr),
    .rd_data_out (tbl_rd_data)
  );

  // Request classification at the sampling point
  always_comb begin
    kind = CIA_KIND_NONE;
    if (last_clock_in && state == CIA_IDLE && !bus_granted_in) begin
      if (nmi_req_in) begin
        kind = CIA_KIND_NMI;
      end else if (int_req_in && int_enabled) begin
        kind = CIA_KIND_INT;
      end
    end
  end

  // Table read address follows the sequence step
  always_comb begin
    tbl_rd_addr = (state == CIA_TBL_LO) ? vec : 8'(vec + 8'h01);
  end

  // Next-state logic
  always_comb begin
    next_state            = state;
    next_mode_select_high = mode_select_high;
    next_mode_select_low  = mode_select_low;
    next_int_enabled      = int_enabled;
    next_wait_cnt         = wait_cnt;
    next_vec              = vec;
    next_tbl_lo           = tbl_lo;
    next_ack              = '0;
    next_jump             = '0;
    if (enable_set_in) next_int_enabled = 1'b1;
    if (enable_clr_in) next_int_enabled = 1'b0;
    if (mode_wr_in && mode_code_in != 2'h1) begin
      next_mode_select_high = mode_code_in[1];
      next_mode_select_low  = mode_code_in[0];
    end
    case (state)
      CIA_IDLE: begin
        if (kind == CIA_KIND_NMI) begin
          next_jump.valid = 1'b1;
          next_jump.addr  = `CIA_NMI_RESTART;
          next_int_enabled = 1'b0;
          next_state = CIA_DONE;
        end else if (kind == CIA_KIND_INT) begin
          next_int_enabled = 1'b0;
          next_ack.opcode_fetch_cycle = 1'b1;
          next_state = CIA_ACK_T1;
        end
      end
      CIA_ACK_T1: begin
        next_ack.opcode_fetch_cycle = 1'b1;
        next_ack.io_request_strobe  = 1'b1;
        next_ack.wait_inserted      = 1'b1;
        next_wait_cnt = `CIA_ACK_WAITS - 2'h1;
        next_state = CIA_ACK_WAIT;
      end
      CIA_ACK_WAIT: begin
        next_ack.opcode_fetch_cycle = 1'b1;
        next_ack.io_request_strobe  = 1'b1;
        if (wait_cnt != 2'h0) begin
          next_ack.wait_inserted = 1'b1;
          next_wait_cnt = wait_cnt - 2'h1;
        end else begin
          next_state = CIA_ACK_T3;
        end
      end
      CIA_ACK_T3: begin
        next_vec = data_bus_in;
        if ({mode_select_high, mode_select_low} == `CIA_MODE1_CODE) begin
          next_jump.valid = 1'b1;
          next_jump.addr  = `CIA_MODE1_RESTART;
          next_state = CIA_DONE;
        end else if ({mode_select_high, mode_select_low} == `CIA_MODE2_CODE) begin
          next_state = CIA_TBL_LO;
        end else begin
          next_jump.valid    = 1'b1;
          next_jump.is_instr = 1'b1;
          next_jump.instr    = data_bus_in;
          next_state = CIA_DONE;
        end
      end
      CIA_TBL_LO: begin
        next_state = CIA_TBL_HI;
      end
      CIA_TBL_HI: begin
        next_tbl_lo = tbl_rd_data;
        next_jump.valid = 1'b1;
        next_jump.addr  = {vector_page_in, vec};
        next_state = CIA_DONE;
      end
      CIA_DONE: begin
        next_state = CIA_IDLE;
      end
      default: begin
        next_state = CIA_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state            <= CIA_IDLE;
      mode_select_high <= 1'(`CIA_MODE_RESET >> 1);
      mode_select_low  <= 1'(`CIA_MODE_RESET);
      int_enabled      <= 1'b0;
      wait_cnt         <= 2'h0;
      vec              <= 8'h00;
      tbl_lo           <= 8'h00;
      ack              <= '0;
      jump             <= '0;
    end else begin
      state            <= next_state;
      mode_select_high <= next_mode_select_high;
      mode_select_low  <= next_mode_select_low;
      int_enabled      <= next_int_enabled;
      wait_cnt         <= next_wait_cnt;
      vec              <= next_vec;
      tbl_lo           <= next_tbl_lo;
      ack              <= next_ack;
      jump             <= next_jump;
    end
  end

  // Outputs straight from flops
  assign opcode_fetch_cycle_out    = ack.opcode_fetch_cycle;
  assign io_request_strobe_out     = ack.io_request_strobe;
  assign memory_request_strobe_out = ack.memory_request_strobe;
  assign wait_out                  = ack.wait_inserted;
  assign jump_valid_out            = jump.valid;
  assign jump_addr_out             = jump.addr;
  assign jump_is_instr_out         = jump.is_instr;
  assign jump_instr_out            = jump.instr;
  assign mode_select_high_out      = mode_select_high;
  assign mode_select_low_out       = mode_select_low;
  assign int_enabled_out           = int_enabled;

  // Assertions
  chk_nmi_first: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (last_clock_in && state == CIA_IDLE && !bus_granted_in && nmi_req_in)
      |=> (jump_valid_out && jump_addr_out == 16'h0066 && !io_request_strobe_out))
    else $error("nmi not taken first");
  chk_int_masked: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == CIA_IDLE && !int_enabled && !nmi_req_in) |=> !opcode_fetch_cycle_out)
    else $error("masked request acknowledged");
  chk_sample_point: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == CIA_IDLE && !last_clock_in) |=> (state == CIA_IDLE && !jump_valid_out))
    else $error("request taken off sampling point");
  chk_mode_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(mode_select_low && !mode_select_high))
    else $error("unused mode code held");
  chk_mode1_addr: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == CIA_ACK_T3 && mode_select_high && !mode_select_low)
      |=> (jump_valid_out && jump_addr_out == 16'h0038))
    else $error("mode 1 restart wrong");
  chk_mode2_ptr: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state == CIA_ACK_T3 && mode_select_high && mode_select_low)
      |=> ##2 (jump_valid_out && jump_addr_out == {$past(vector_page_in), $past(data_bus_in, 3)}))
    else $error("mode 2 pointer wrong");
  chk_ack_waits: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $rose(io_request_strobe_out) |-> (wait_out && !memory_request_strobe_out) ##1 wait_out ##1 !wait_out)
    else $error("acknowledge wait count wrong");
  chk_nmi_fixed: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (jump_valid_out && !jump_is_instr_out && $past(state) == CIA_IDLE) |-> jump_addr_out == 16'h0066)
    else $error("nmi restart wrong");
  cov_nmi:   cover property (@(posedge clk_in) disable iff (!rstn_in) jump_valid_out && jump_addr_out == 16'h0066);
  cov_mode0: cover property (@(posedge clk_in) disable iff (!rstn_in) jump_valid_out && jump_is_instr_out);
  cov_mode1: cover property (@(posedge clk_in) disable iff (!rstn_in) jump_valid_out && jump_addr_out == 16'h0038);
  cov_mode2: cover property (@(posedge clk_in) disable iff (!rstn_in) state == CIA_TBL_HI);
endmodule : cia_accept

// >>> hdl/cia_defs.svh
// Behaviour
// - Non-maskable request outranks the maskable request
// - Maskable request ignored while interrupts disabled
// - Sample both requests at instruction's last clock
// - One fixed non-maskable response sequence
// - Three software-selectable maskable response modes
// - Mode flops: 00 mode0, 10 mode1, 11 mode2
// - Non-maskable restart at 0066H unless bus granted
// - Mode 1 restarts at 0038H
// - Mode 2 pointer: vector page high, vector low
// - Acknowledge: io strobe, no memory strobe, two waits
`ifndef CIA_DEFS_SVH
`define CIA_DEFS_SVH
`define CIA_NMI_RESTART   16'h0066
`define CIA_MODE1_RESTART 16'h0038
`define CIA_ACK_WAITS     2'h2
`define CIA_MODE_RESET    2'h0
`define CIA_MODE0_CODE    2'h0
`define CIA_MODE1_CODE    2'h2
`define CIA_MODE2_CODE    2'h3
`define CIA_VEC_WIDTH     8
`define CIA_TABLE_DEPTH   4
`endif

// >>> hdl/cia_pkg.sv
package cia_pkg;
  typedef enum logic [1:0] {
    CIA_KIND_NONE,
    CIA_KIND_NMI,
    CIA_KIND_INT
  } cia_kind_e;

  typedef enum {
    CIA_IDLE,
    CIA_ACK_T1,
    CIA_ACK_WAIT,
    CIA_ACK_T3,
    CIA_TBL_LO,
    CIA_TBL_HI,
    CIA_DONE
  } cia_state_e;

  // Jump result handed to the sequencer
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        is_instr;
    logic [7:0]  instr;
  } cia_jump_s;

  // Acknowledge cycle strobes
  typedef struct packed {
    logic opcode_fetch_cycle;
    logic io_request_strobe;
    logic memory_request_strobe;
    logic wait_inserted;
  } cia_ack_s;
endpackage : cia_pkg

// >>> hdl/cia_table_mem.sv
`include "cia_defs.svh"
// Small table memory for mode 2 vector entries, registered read
module cia_table_mem
  import cia_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // Clock
  input  wire logic                     clk_in,
  // Write side
  input  wire logic                     wr_en_in,
  input  wire logic [7:0]               wr_addr_in,
  input  wire logic [7:0]               wr_data_in,
  // Read side
  input  wire logic [7:0]               rd_addr_in,
  output logic      [7:0]               rd_data_out
);
  logic [7:0] mem [DEPTH];

  // Byte store and registered read
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule : cia_table_mem

// >>> tb/cia_accept_tb_top.sv
module cia_accept_tb_top
  import cia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rstn_in;
  logic        nmi_req, last_clock, bus_granted, en_set, en_clr, mode_wr, clr, got, mem_seen, j_is;
  logic [1:0]  mode_code, raise;
  logic [7:0]  page, j_instr;
  logic [15:0] j_addr;
  wire         int_req, fetch, io, mem, wt, jv, jii, msh, msl, ien;
  wire  [7:0]  data_bus, jin;
  wire  [15:0] ja;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          n_io, n_wait, n_fetch;

  // Clock
  always #25 clk_in = ~clk_in;

  // Block and far side
  cia_accept i_cia_accept (.clk_in(clk_in), .rstn_in(rstn_in), .nmi_req_in(nmi_req), .int_req_in(int_req),
    .last_clock_in(last_clock), .bus_granted_in(bus_granted), .enable_set_in(en_set), .enable_clr_in(en_clr),
    .mode_wr_in(mode_wr), .mode_code_in(mode_code), .vector_page_in(page), .data_bus_in(data_bus),
    .tbl_wr_in(1'b0), .tbl_addr_in(8'h00), .tbl_data_in(8'h00), .opcode_fetch_cycle_out(fetch),
    .io_request_strobe_out(io), .memory_request_strobe_out(mem), .wait_out(wt), .jump_valid_out(jv),
    .jump_addr_out(ja), .jump_is_instr_out(jii), .jump_instr_out(jin), .mode_select_high_out(msh),
    .mode_select_low_out(msl), .int_enabled_out(ien));
  cia_periph_model i_cia_periph_model (.clk_in(clk_in), .rstn_in(rstn_in), .raise_in(raise), .clr_in(clr),
    .vec_base_in(8'h40), .io_request_strobe_in(io), .opcode_fetch_cycle_in(fetch), .jump_valid_in(jv),
    .int_req_out(int_req), .data_out(data_bus));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Software pulses for enable and mode
  task automatic sw(input logic set, input logic wr, input logic [1:0] code);
    @(posedge clk_in);
    en_set <= set;
    mode_wr <= wr;
    mode_code <= code;
    @(posedge clk_in);
    en_set <= 1'b0;
    mode_wr <= 1'b0;
    #1;
  endtask : sw

  // Raise requests, give one sampling point, record the response
  task automatic run(input logic nmi, input logic [1:0] irq, input logic lc, input logic exp_jump);
    @(posedge clk_in);
    nmi_req <= nmi;
    raise <= irq;
    @(posedge clk_in);
    raise <= 2'h0;
    last_clock <= lc;
    @(posedge clk_in);
    last_clock <= 1'b0;
    got = 1'b0;
    n_io = 0;
    n_wait = 0;
    n_fetch = 0;
    mem_seen = 1'b0;
    for (int i = 0; i < 20 && !got; i++) begin
      #1;
      n_io += (io === 1'b1) ? 1 : 0;
      n_wait += (wt === 1'b1) ? 1 : 0;
      n_fetch += (fetch === 1'b1) ? 1 : 0;
      mem_seen |= (mem !== 1'b0);
      got = (jv === 1'b1);
      {j_addr, j_is, j_instr} = {ja, jii, jin};
      @(posedge clk_in);
    end
    check({15'h0, got}, {15'h0, exp_jump});
    if (exp_jump && !got) wrap_up();
    nmi_req <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : run

  task automatic t_reset();
    @(posedge clk_in);
    #1;
    check({8'h00, msh, msl, ien, jv, fetch, io, mem, wt}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_refuse();
    sw(1'b1, 1'b1, 2'h1);
    check({13'h0, ien, msh, msl}, 16'h0004);
    // Set and clear together: clear wins
    @(posedge clk_in);
    en_set <= 1'b1;
    en_clr <= 1'b1;
    @(posedge clk_in);
    en_set <= 1'b0;
    en_clr <= 1'b0;
    #1;
    check({15'h0, ien}, 16'h0000);
    run(1'b0, 2'h1, 1'b1, 1'b0);
    check(16'(n_io), 16'h0000);
    run(1'b1, 2'h0, 1'b0, 1'b0);
    @(posedge clk_in);
    bus_granted <= 1'b1;
    run(1'b1, 2'h0, 1'b1, 1'b0);
    check({15'h0, got}, 16'h0000);
    bus_granted <= 1'b0;
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_modes();
    logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
    for (int m = 0; m < 3; m++) begin
      sw(1'b1, 1'b1, codes[m]);
      check({14'h0, msh, msl}, {14'h0, codes[m]});
      check({15'h0, ien}, 16'h0001);
      run(1'b0, 2'h1, 1'b1, 1'b1);
      check(16'(n_wait), 16'h0002);
      check(16'(n_fetch), 16'h0004);
      check({15'(n_io), mem_seen}, 16'h0006);
      check({15'h0, ien}, 16'h0000);
      if (m == 0) check({7'h0, j_is, j_instr}, 16'h0140);
      if (m == 1) check(j_addr, 16'h0038);
      if (m == 2) check(j_addr, {page, 8'h40});
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_prio();
    sw(1'b1, 1'b0, 2'h0);
    run(1'b1, 2'h3, 1'b1, 1'b1);
    check({j_addr[14:0], j_is}, 16'h00cc);
    sw(1'b1, 1'b0, 2'h0);
    run(1'b0, 2'h0, 1'b1, 1'b1);
    check(j_addr, {page, 8'h40});
    sw(1'b1, 1'b0, 2'h0);
    run(1'b0, 2'h0, 1'b1, 1'b1);
    check(j_addr, {page, 8'h42});
    $display("test priority done");
  endtask : t_prio

  // Main sequence
  initial begin
    {rstn_in, nmi_req, last_clock, bus_granted, en_set, en_clr, mode_wr, clr} = 8'h00;
    {mode_code, raise, page} = 12'h05a;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_refuse();
    t_modes();
    t_prio();
    // Mid-run reset must drop mode 2 and the enable
    sw(1'b1, 1'b1, 2'h3);
    check({13'h0, ien, msh, msl}, 16'h0007);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    wrap_up();
  end
endmodule : cia_accept_tb_top

// >>> tb/cia_periph_model.sv
// Two peripherals sharing the maskable line, answering acknowledge
module cia_periph_model
  import cia_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Bench control
  input  wire logic [1:0] raise_in,
  input  wire logic       clr_in,
  input  wire logic [7:0] vec_base_in,
  // Acknowledge from the block
  input  wire logic       io_request_strobe_in,
  input  wire logic       opcode_fetch_cycle_in,
  input  wire logic       jump_valid_in,
  // Shared lines
  output logic            int_req_out,
  output logic [7:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pending;
  logic       acking;
  logic       ack_idx;
  logic [7:0] last_data;
  logic [1:0] win;
  logic       start;

  // Wired-OR of the pending requests, lowest index served first
  assign int_req_out = |pending;
  assign win         = pending[0] ? 2'h1 : 2'h2;
  assign start       = io_request_strobe_in && opcode_fetch_cycle_in && !acking;
  // Vector while acknowledging, else a changed level on the bus
  assign data_out    = acking ? {vec_base_in[7:2], ack_idx, 1'b0} : ~last_data;

  // Request and acknowledge tracking
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pending   <= 2'h0;
      acking    <= 1'b0;
      ack_idx   <= 1'b0;
      last_data <= 8'h00;
    end else begin
      if (clr_in) begin
        pending <= 2'h0;
      end else if (start) begin
        pending <= (pending & ~win) | raise_in;
      end else begin
        pending <= pending | raise_in;
      end
      if (start) begin
        acking  <= 1'b1;
        ack_idx <= ~pending[0];
      end else if (jump_valid_in) begin
        acking <= 1'b0;
      end
      if (acking) begin
        last_data <= data_out;
      end
    end
  end
endmodule : cia_periph_model
